// *** hdl/pcc_consts.vh ***
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH
// Register word addresses (byte address = 4 x index)
`define PCC_ADDR_MODE 4'h0
`define PCC_ADDR_VLOW 4'h1
`define PCC_ADDR_VHIGH 4'h2
`define PCC_ADDR_WCFG 4'h3
`define PCC_ADDR_STAT 4'h4
`define PCC_ADDR_COUNT 4'h5
`define PCC_ADDR_PIN 4'h6
// Mode register bit positions
`define PCC_B_IRQ 0
`define PCC_B_PWM 1
`define PCC_B_TOG 2
`define PCC_B_MAT 3
`define PCC_B_FALL 4
`define PCC_B_RISE 5
`define PCC_B_ECOM 6
// Width config bit positions
`define PCC_B_CLS_LO 0
`define PCC_B_CLS_HI 1
`define PCC_B_OVIE 5
`define PCC_B_RSEL 7
// Status bit positions
`define PCC_B_CEF 0
`define PCC_B_SOVF 1
// Reset values
`define PCC_MODE_RST 8'h00
`define PCC_WCFG_RST 8'h00
`define PCC_VAL_RST 16'h0000
`endif

// *** hdl/pcc_channel.v ***
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "pcc_consts.vh"
module pcc_channel (
    // Clock and reset
    input wire MCLK,
    input wire RESET_N,
    // Counter array timebase
    input wire COUNT_TICK,
    input wire [15:0] COUNT_VALUE,
    // Avalon-MM slave
    input wire [3:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output reg AVS_WAITREQUEST,
    // Channel pin
    input wire CHANNEL_IO_PIN_I,
    output reg CHANNEL_IO_PIN_O,
    output reg CHANNEL_IO_PIN_OE,
    // Interrupt request
    output reg IRQ
);
    reg pin_s1_reg, pin_s2_reg, pin_s3_reg;
    reg [7:0] mode_reg, wcfg_reg;
    reg [15:0] value_reg, reload_reg;
    reg event_reg, ovf_reg, out_reg, ack_reg;
    wire cap_rise = mode_reg[`PCC_B_RISE];
    wire cap_fall = mode_reg[`PCC_B_FALL];
    wire ecom = mode_reg[`PCC_B_ECOM];
    wire mat = mode_reg[`PCC_B_MAT];
    wire tog = mode_reg[`PCC_B_TOG];
    wire pwm = mode_reg[`PCC_B_PWM];
    wire [1:0] cls = wcfg_reg[`PCC_B_CLS_HI:`PCC_B_CLS_LO];
    wire reload_sel = wcfg_reg[`PCC_B_RSEL];
    // Mode decode
    wire capture_mode = cap_rise | cap_fall;
    wire freq_mode = !capture_mode & ecom & tog & pwm;
    wire pwm_mode = !capture_mode & pwm & !tog;
    wire cmp_mode = !capture_mode & !pwm;
    // Capture edge detect reads only the second and third stage
    wire rise_edge = pin_s2_reg & !pin_s3_reg;
    wire fall_edge = !pin_s2_reg & pin_s3_reg;
    wire capture_hit = (cap_rise & rise_edge) | (cap_fall & fall_edge);
    // Counter lengths and wrap detection
    reg [15:0] len_mask;
    always @* begin
        case (cls)
            2'b00: len_mask = 16'h00FF;
            2'b01: len_mask = 16'h01FF;
            2'b10: len_mask = 16'h03FF;
            default: len_mask = 16'h07FF;
        endcase
    end
    // Wrap seen when masked counter is at its top and a tick arrives
    wire short_wrap = COUNT_TICK & ((COUNT_VALUE & len_mask) == len_mask);
    wire full_match = COUNT_TICK & (COUNT_VALUE == value_reg);
    wire low_match = COUNT_TICK & (COUNT_VALUE[7:0] == value_reg[7:0]);
    // Width match looks at the count being entered, so the high time
    // covers the matched count itself and the duty is not one count short
    wire [15:0] count_next = COUNT_VALUE + 16'h0001;
    wire pwm_match = COUNT_TICK
        & ((count_next & len_mask) == (value_reg & len_mask));
    // Value that takes over at a wrap; zero means the pin stays high
    wire wrap_zero = (cls == 2'b00) ? (value_reg[15:8] == 8'h00)
        : ((reload_reg & len_mask) == 16'h0000);
    // Bus write decode; one wait cycle makes every access two cycles
    wire req = (AVS_READ | AVS_WRITE) & !ack_reg;
    wire wr_go = AVS_WRITE & ack_reg;
    wire wr_low = wr_go & (AVS_ADDRESS == `PCC_ADDR_VLOW) & AVS_BYTEENABLE[0];
    wire wr_high = wr_go & (AVS_ADDRESS == `PCC_ADDR_VHIGH) & AVS_BYTEENABLE[0];
    wire wr_mode = wr_go & (AVS_ADDRESS == `PCC_ADDR_MODE) & AVS_BYTEENABLE[0];
    wire wr_wcfg = wr_go & (AVS_ADDRESS == `PCC_ADDR_WCFG) & AVS_BYTEENABLE[0];
    wire wr_stat = wr_go & (AVS_ADDRESS == `PCC_ADDR_STAT) & AVS_BYTEENABLE[0];
    // Hardware events
    wire ev_set = (capture_mode & capture_hit)
        | (cmp_mode & ecom & mat & full_match)
        | (freq_mode & mat & full_match)
        | (pwm_mode & ecom & mat & pwm_match);
    wire ov_set = pwm_mode & short_wrap;

    // Pin synchroniser, two stages before use plus one history stage
    // Resets to the idle high level so no false edge follows reset
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_s3_reg <= 1'b1;
        end else begin
            pin_s1_reg <= CHANNEL_IO_PIN_I;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // Configuration registers
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_reg <= `PCC_MODE_RST;
            wcfg_reg <= `PCC_WCFG_RST;
        end else begin
            if (wr_wcfg)
                wcfg_reg <= AVS_WRITEDATA[7:0];
            if (wr_mode)
                mode_reg <= AVS_WRITEDATA[7:0];
            else if (wr_low & !reload_sel)
                mode_reg[`PCC_B_ECOM] <= 1'b0;
            else if (wr_high & !reload_sel)
                mode_reg[`PCC_B_ECOM] <= 1'b1;
        end
    end

    // Channel value and auto-reload registers
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            value_reg <= `PCC_VAL_RST;
            reload_reg <= `PCC_VAL_RST;
        end else begin
            // Hardware updates first; a same-cycle software write wins below
            if (capture_mode & capture_hit)
                value_reg <= COUNT_VALUE;
            else if (freq_mode & ecom & low_match)
                value_reg[7:0] <= value_reg[7:0] + value_reg[15:8];
            else if (pwm_mode & short_wrap & (cls == 2'b00))
                value_reg[7:0] <= value_reg[15:8];
            else if (pwm_mode & short_wrap)
                value_reg <= reload_reg & len_mask;
            if (wr_low & reload_sel)
                reload_reg[7:0] <= AVS_WRITEDATA[7:0];
            if (wr_high & reload_sel)
                reload_reg[15:8] <= AVS_WRITEDATA[7:0];
            if (wr_low & !reload_sel)
                value_reg[7:0] <= AVS_WRITEDATA[7:0];
            if (wr_high & !reload_sel)
                value_reg[15:8] <= AVS_WRITEDATA[7:0];
        end
    end

    // Status flags: set beats a same-cycle software clear
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            event_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            if (ev_set)
                event_reg <= 1'b1;
            else if (wr_stat & !AVS_WRITEDATA[`PCC_B_CEF])
                event_reg <= 1'b0;
            if (ov_set)
                ovf_reg <= 1'b1;
            else if (wr_stat & !AVS_WRITEDATA[`PCC_B_SOVF])
                ovf_reg <= 1'b0;
        end
    end

    // Output generator
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_reg <= 1'b0;
        end else if (pwm_mode) begin
            if (!ecom)
                out_reg <= 1'b0;
            else if (short_wrap)
                out_reg <= wrap_zero;
            else if (pwm_match)
                out_reg <= 1'b1;
        end else if (freq_mode) begin
            if (low_match)
                out_reg <= !out_reg;
        end else if (cmp_mode & tog & ecom & full_match) begin
            out_reg <= !out_reg;
        end
    end

    // Pin drive: released in capture and timer modes so the pin reads back
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CHANNEL_IO_PIN_O <= 1'b0;
            CHANNEL_IO_PIN_OE <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            CHANNEL_IO_PIN_O <= out_reg;
            CHANNEL_IO_PIN_OE <= pwm_mode | freq_mode | (cmp_mode & tog);
            IRQ <= (event_reg & mode_reg[`PCC_B_IRQ])
                | (ovf_reg & wcfg_reg[`PCC_B_OVIE]);
        end
    end

    // Avalon slave: waitrequest high on the first cycle of a request
    always @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_reg <= 1'b0;
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else begin
            ack_reg <= req;
            AVS_WAITREQUEST <= !req;
            if (req & AVS_READ) begin
                case (AVS_ADDRESS)
                    `PCC_ADDR_MODE: AVS_READDATA <= {24'h000000, mode_reg};
                    `PCC_ADDR_VLOW: AVS_READDATA <= {24'h000000,
                        reload_sel ? reload_reg[7:0] : value_reg[7:0]};
                    `PCC_ADDR_VHIGH: AVS_READDATA <= {24'h000000,
                        reload_sel ? reload_reg[15:8] : value_reg[15:8]};
                    `PCC_ADDR_WCFG: AVS_READDATA <= {24'h000000, wcfg_reg};
                    `PCC_ADDR_STAT: AVS_READDATA <= {30'h00000000, ovf_reg, event_reg};
                    `PCC_ADDR_COUNT: AVS_READDATA <= {16'h0000, COUNT_VALUE};
                    `PCC_ADDR_PIN: AVS_READDATA <= {31'h00000000, pin_s2_reg};
                    default: AVS_READDATA <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // pcc_channel
`default_nettype wire

// *** tb/pcc_pin_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcc_pin_model (
    // Bench control of the far-side driver
    input wire logic drv_en,
    input wire logic drv_lvl,
    // Channel side
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_w
);
    // Pull-up wins when nobody drives, so a released line never shows stale data
    assign pin_w = pin_oe ? pin_o : (drv_en ? drv_lvl : 1'b1);
endmodule // pcc_pin_model
`default_nettype wire

// *** tb/pcc_channel_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcc_channel_props (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // Watched inputs
    input wire logic COUNT_TICK,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    // Watched outputs
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic CHANNEL_IO_PIN_O
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // Access steps: request waiting, then read answered
    sequence s_req; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
    sequence s_rd_done; AVS_READ && !AVS_WAITREQUEST; endsequence
    property p_ack; s_req |=> !AVS_WAITREQUEST; endproperty
    a_ack: assert property (p_ack) else $error("access not answered");
    property p_ack_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
    a_ack_one: assert property (p_ack_one) else $error("answer longer than one cycle");
    property p_no_req; !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST; endproperty
    a_no_req: assert property (p_no_req) else $error("answer without request");
    property p_hold; !(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA); endproperty
    a_hold: assert property (p_hold) else $error("read data moved between reads");
    property p_unmapped; s_rd_done and AVS_ADDRESS > 4'h6 |-> AVS_READDATA == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stat; s_rd_done and AVS_ADDRESS == 4'h4 |-> AVS_READDATA[31:2] == 30'h0; endproperty
    a_stat: assert property (p_stat) else $error("status read too wide");
    property p_upper; !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data upper half set");
    // Every rising pin edge traces back to a counter step two cycles earlier
    property p_pin_rise; $rose(CHANNEL_IO_PIN_O) |-> $past(COUNT_TICK, 2); endproperty
    a_pin_rise: assert property (p_pin_rise)
        else $error("pin rose without counter step");
endmodule // pcc_channel_props
bind pcc_channel pcc_channel_props props_u (
    .MCLK(MCLK), .RESET_N(RESET_N), .COUNT_TICK(COUNT_TICK), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CHANNEL_IO_PIN_O(CHANNEL_IO_PIN_O));
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic MCLK, RESET_N = 1'b0, COUNT_TICK = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic drv_en = 1'b0, drv_lvl = 1'b0, AVS_WAITREQUEST, pin_o, pin_oe, pin_w, IRQ;
    logic [15:0] COUNT_VALUE = 16'h0000, tgt;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
    int err_total = 0, cmp_count = 0, cyc = 0, hi;
    pcc_channel dut_u (.MCLK(MCLK), .RESET_N(RESET_N), .COUNT_TICK(COUNT_TICK),
        .COUNT_VALUE(COUNT_VALUE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
        .CHANNEL_IO_PIN_I(pin_w), .CHANNEL_IO_PIN_O(pin_o), .CHANNEL_IO_PIN_OE(pin_oe));
    pcc_pin_model pin_u (.drv_en(drv_en), .drv_lvl(drv_lvl), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_w(pin_w));
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    // Counter stand-in and hang guard
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (COUNT_TICK)
            COUNT_VALUE <= COUNT_VALUE + 16'h0001;
        if (cyc == 5000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end
    // One bus access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge MCLK);
        AVS_ADDRESS <= a;
        AVS_WRITE <= w;
        AVS_READ <= ~w;
        AVS_WRITEDATA <= {24'h000000, d};
        do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count = cmp_count + 1;
        if (s !== e) begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e, input string n);
        acc(1'b0, a, 8'h00);
        chk(n, rd, e);
    endtask
    // Counts high pin cycles over a window
    task automatic cnt_hi(input int n);
        hi = 0;
        repeat (n) begin
            @(posedge MCLK);
            hi = hi + (pin_w === 1'b1);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge MCLK);
        RESET_N <= 1'b1;
        COUNT_TICK <= 1'b1;
        rc(4'h0, 32'h0, "mode_reset");
        rc(4'h7, 32'h0, "unmapped");
        $display("test reset done");
        // Timer armed only by the high byte write
        acc(1'b1, 4'h0, 8'h48);
        tgt = COUNT_VALUE + 16'h0080;
        acc(1'b1, 4'h1, tgt[7:0]);
        rc(4'h0, 32'h08, "mode_low_write");
        acc(1'b1, 4'h2, tgt[15:8]);
        rc(4'h0, 32'h48, "mode_high_write");
        repeat (200) @(posedge MCLK);
        rc(4'h4, 32'h01, "timer_flag");
        chk("irq_masked", {31'h0, IRQ}, 32'h0);
        acc(1'b1, 4'h0, 8'h49);
        rc(4'h4, 32'h01, "flag_kept");
        chk("irq_on", {31'h0, IRQ}, 32'h1);
        acc(1'b1, 4'h4, 8'h00);
        rc(4'h4, 32'h0, "flag_cleared");
        chk("irq_off", {31'h0, IRQ}, 32'h0);
        $display("test timer done");
        // Low byte starts wrong so only the reload gives the right duty
        acc(1'b1, 4'h0, 8'h42);
        acc(1'b1, 4'h1, 8'h10);
        acc(1'b1, 4'h2, 8'hC0);
        repeat (600) @(posedge MCLK);
        cnt_hi(512);
        chk("duty", hi, 128);
        rc(4'h4, 32'h02, "short_overflow");
        acc(1'b1, 4'h1, 8'h00);
        repeat (4) @(posedge MCLK);
        cnt_hi(256);
        chk("zero_duty", hi, 0);
        $display("test width done");
        // Capture with the count frozen so the value is known
        COUNT_TICK <= 1'b0;
        acc(1'b1, 4'h4, 8'h00);
        acc(1'b1, 4'h0, 8'h30);
        drv_en <= 1'b1;
        repeat (4) @(posedge MCLK);
        drv_lvl <= 1'b1;
        repeat (8) @(posedge MCLK);
        drv_lvl <= 1'b0;
        repeat (8) @(posedge MCLK);
        rc(4'h1, {24'h0, COUNT_VALUE[7:0]}, "capture_low");
        rc(4'h2, {24'h0, COUNT_VALUE[15:8]}, "capture_high");
        rc(4'h4, 32'h01, "capture_flag");
        rc(4'h6, 32'h0, "pin_level");
        $display("test capture done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
